// ---- pkg/ire_cfg.svh ----
// Register indices, field positions, reset values for the request bank
`ifndef IRE_CFG_SVH
`define IRE_CFG_SVH

// ****************************************
// Register indices (byte address = index * 4)
// ****************************************
`define IRE_IDX_W 12
`define IRE_IDX_REQ 12'hfc0
`define IRE_IDX_ENH 12'hfc1
`define IRE_IDX_ENL 12'hfc2
`define IRE_IDX_STAT 12'hfc4
`define IRE_IDX_MASK 12'hfc5
`define IRE_IDX_CLR 12'hfc6

// ****************************************
// Widths
// ****************************************
`define IRE_ADDR_W 14
`define IRE_REG_W 8
`define IRE_DATA_W 32
`define IRE_SRC_IDX_W 3

// ****************************************
// Field positions
// ****************************************
`define IRE_BIT_TIMER_B 6
`define IRE_BIT_TIMER_A 5
`define IRE_BIT_SERIAL_RX 4
`define IRE_BIT_SERIAL_TX 3
`define IRE_BIT_CONVERTER 0
`define IRE_IMPL_MASK 8'h79

// ****************************************
// Reset values
// ****************************************
`define IRE_RST_BYTE 8'h00
`define IRE_RST_WORD 32'h0000_0000

`endif

// ---- pkg/ire_pkg.sv ----
// Types shared by the request bank design files
`include "ire_cfg.svh"

package ire_pkg;

  typedef logic [`IRE_REG_W-1:0] ire_byte_t;

  typedef enum logic [1:0] {
    IRE_LVL_OFF = 2'h0,
    IRE_LVL_LOW = 2'h1,
    IRE_LVL_NOM = 2'h2,
    IRE_LVL_HIGH = 2'h3
  } ire_level_e;

  typedef enum logic {
    IRE_BUS_IDLE = 1'h0,
    IRE_BUS_ANSWER = 1'h1
  } ire_bus_e;

  typedef struct packed {
    logic timerBRequest;
    logic timerARequest;
    logic serialRxRequest;
    logic serialTxRequest;
    logic converterRequest;
  } ire_src_s;

  typedef struct packed {
    logic watchdogIrq;
    logic primaryOscFail;
    logic watchdogOscFail;
  } ire_trap_s;

  typedef struct packed {
    logic valid;
    logic [`IRE_SRC_IDX_W-1:0] source;
    ire_level_e level;
  } ire_vec_s;

  typedef struct packed {
    ire_bus_e bus;
    logic [`IRE_DATA_W-1:0] readData;
    ire_byte_t req;
    ire_byte_t enh;
    ire_byte_t enl;
    ire_byte_t stat;
    ire_byte_t mask;
    logic irq;
    ire_vec_s vec;
    ire_trap_s trap;
  } ire_state_s;

endpackage

// ---- hdl/ire_prio_sel.sv ----
// Priority selector: picks the pending enabled source of highest level
`timescale 1ns/10ps
`include "ire_cfg.svh"

module ire_prio_sel #(
  parameter int unsigned WIDTH = `IRE_REG_W
) (
  input wire logic [WIDTH-1:0] pending,
  input wire logic [WIDTH-1:0] enableHigh,
  input wire logic [WIDTH-1:0] enableLow,
  output ire_pkg::ire_vec_s winner
);
  import ire_pkg::*;

  logic [1:0] bestLvl [WIDTH+1];
  logic [`IRE_SRC_IDX_W-1:0] bestIdx [WIDTH+1];

  assign bestLvl[0] = IRE_LVL_OFF;
  assign bestIdx[0] = '0;

  // ****************************************
  // Scan, later bits win ties
  // ****************************************
  for (genvar i = 0; i < WIDTH; i++) begin : g_scan
    logic [1:0] lvl;
    logic take;
    assign lvl = pending[i] ? {enableHigh[i], enableLow[i]} : 2'h0;
    assign take = (lvl != 2'h0) && (lvl >= bestLvl[i]);
    assign bestLvl[i+1] = take ? lvl : bestLvl[i];
    assign bestIdx[i+1] = take ? `IRE_SRC_IDX_W'(i) : bestIdx[i];
  end

  assign winner.valid = bestLvl[WIDTH] != 2'h0;
  assign winner.source = bestIdx[WIDTH];
  assign winner.level = ire_level_e'(bestLvl[WIDTH]);

endmodule

// ---- hdl/ire_request_enable_bank.sv ----
// Interrupt request group 0: pending bits, priority enables, vectoring
//
// Functional notes
// - A request from any source sets and holds its pending bit in the request register.
// - With interrupts globally enabled a pending enabled request is offered as a vector.
// - The request register keeps timer B pending in bit 6 and timer A pending in bit 5.
// - Serial receive sits in bit 4, serial transmit in bit 3, converter in bit 0, others zero.
// - The low enable register has one writable bit per source, reserved bits read zero.
// - A high enable register gives each source a high bit paired with its low bit.
// - Watchdog and oscillator fail traps bypass the request, enable and priority logic.
`timescale 1ns/10ps
`include "ire_cfg.svh"

module ire_request_enable_bank (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [`IRE_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [`IRE_DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [`IRE_DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  input ire_pkg::ire_src_s sources,
  input wire logic globalIntEnable,
  input wire logic vecAck,
  output logic vecReq,
  output logic [`IRE_SRC_IDX_W-1:0] vecSource,
  output ire_pkg::ire_level_e vecLevel,
  input ire_pkg::ire_trap_s trapIn,
  output ire_pkg::ire_trap_s trapOut,
  output logic irqOut
);
  import ire_pkg::*;

  localparam ire_byte_t IMPL = `IRE_IMPL_MASK;

  ire_state_s s_q;
  ire_state_s s_d;
  ire_vec_s win;
  ire_byte_t srcVec;
  logic [`IRE_IDX_W-1:0] idx;
  logic aligned;
  logic hitReq;
  logic hitEnh;
  logic hitEnl;
  logic hitStat;
  logic hitMask;
  logic hitClr;
  logic readTake;
  logic writeTake;
  logic ackTake;
  ire_byte_t wByte;
  ire_byte_t rByte;

  // ****************************************
  // Source mapping into register layout
  // ****************************************
  always_comb begin
    srcVec = `IRE_RST_BYTE;
    srcVec[`IRE_BIT_TIMER_B] = sources.timerBRequest;
    srcVec[`IRE_BIT_TIMER_A] = sources.timerARequest;
    srcVec[`IRE_BIT_SERIAL_RX] = sources.serialRxRequest;
    srcVec[`IRE_BIT_SERIAL_TX] = sources.serialTxRequest;
    srcVec[`IRE_BIT_CONVERTER] = sources.converterRequest;
  end

  // ****************************************
  // Address decode
  // ****************************************
  assign idx = avs_address[`IRE_ADDR_W-1:2];
  assign aligned = avs_address[1:0] == 2'h0;

  always_comb begin
    hitReq = 1'b0;
    hitEnh = 1'b0;
    hitEnl = 1'b0;
    hitStat = 1'b0;
    hitMask = 1'b0;
    hitClr = 1'b0;
    if (!aligned) begin
      hitReq = 1'b0;
    end else if (idx == `IRE_IDX_REQ) begin
      hitReq = 1'b1;
    end else if (idx == `IRE_IDX_ENH) begin
      hitEnh = 1'b1;
    end else if (idx == `IRE_IDX_ENL) begin
      hitEnl = 1'b1;
    end else if (idx == `IRE_IDX_STAT) begin
      hitStat = 1'b1;
    end else if (idx == `IRE_IDX_MASK) begin
      hitMask = 1'b1;
    end else if (idx == `IRE_IDX_CLR) begin
      hitClr = 1'b1;
    end
  end

  // Read data mux, unmapped and write-only read zero
  always_comb begin
    rByte = `IRE_RST_BYTE;
    if (hitReq) begin
      rByte = s_q.req & IMPL;
    end else if (hitEnh) begin
      rByte = s_q.enh & IMPL;
    end else if (hitEnl) begin
      rByte = s_q.enl & IMPL;
    end else if (hitStat) begin
      rByte = s_q.stat;
    end else if (hitMask) begin
      rByte = s_q.mask;
    end
  end

  // ****************************************
  // Bus handshake: one wait cycle per access
  // ****************************************
  assign avs_waitrequest = (avs_read || avs_write) && (s_q.bus == IRE_BUS_IDLE);
  assign readTake = avs_read && (s_q.bus == IRE_BUS_IDLE);
  assign writeTake = avs_write && (s_q.bus == IRE_BUS_ANSWER) && avs_byteenable[0];
  assign wByte = avs_writedata[`IRE_REG_W-1:0];
  assign ackTake = vecAck && s_q.vec.valid;

  // ****************************************
  // Priority selection
  // ****************************************
  ire_prio_sel #(
    .WIDTH(`IRE_REG_W)
  ) u_sel (
    .pending(s_q.req & IMPL),
    .enableHigh(s_q.enh),
    .enableLow(s_q.enl),
    .winner(win)
  );

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    s_d = s_q;
    case (s_q.bus)
      IRE_BUS_IDLE: begin
        if (avs_read || avs_write) begin
          s_d.bus = IRE_BUS_ANSWER;
        end
      end
      IRE_BUS_ANSWER: begin
        s_d.bus = IRE_BUS_IDLE;
      end
      default: begin
        s_d.bus = IRE_BUS_IDLE;
      end
    endcase
    if (readTake) begin
      s_d.readData = {{(`IRE_DATA_W-`IRE_REG_W){1'b0}}, rByte};
    end
    // Request register: software write, vector ack, then hardware set wins
    if (writeTake && hitReq) begin
      s_d.req = wByte & IMPL;
    end
    if (ackTake) begin
      s_d.req[s_q.vec.source] = 1'b0;
    end
    s_d.req = (s_d.req | srcVec) & IMPL;
    if (writeTake && hitEnh) begin
      s_d.enh = wByte & IMPL;
    end
    if (writeTake && hitEnl) begin
      s_d.enl = wByte & IMPL;
    end
    if (writeTake && hitMask) begin
      s_d.mask = wByte & IMPL;
    end
    if (writeTake && hitClr) begin
      s_d.stat = s_q.stat & ~wByte;
    end
    s_d.stat = (s_d.stat | srcVec) & IMPL;
    s_d.irq = |(s_d.stat & s_d.mask);
    // Vector offer, dropped for one cycle after an ack
    if (!globalIntEnable || ackTake) begin
      s_d.vec = '0;
    end else begin
      s_d.vec = win;
    end
    s_d.trap = trapIn;
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign avs_readdata = s_q.readData;
  assign vecReq = s_q.vec.valid;
  assign vecSource = s_q.vec.source;
  assign vecLevel = s_q.vec.level;
  assign trapOut = s_q.trap;
  assign irqOut = s_q.irq;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);

  property p_req_latch;
    (srcVec != 8'h00) |=> ((s_q.req & $past(srcVec)) == $past(srcVec));
  endproperty
  a_req_latch: assert property (p_req_latch)
    else $error("source request not latched");

  property p_req_hold;
    (s_q.req[`IRE_BIT_TIMER_A] && !ackTake && !(writeTake && hitReq))
      |=> s_q.req[`IRE_BIT_TIMER_A] [*1];
  endproperty
  a_req_hold: assert property (p_req_hold)
    else $error("pending request lost");

  property p_vec_fwd;
    (globalIntEnable && !ackTake) |=> (vecReq == $past(win.valid));
  endproperty
  a_vec_fwd: assert property (p_vec_fwd)
    else $error("vector not offered while enabled");

  property p_vec_off;
    !globalIntEnable |=> !vecReq;
  endproperty
  a_vec_off: assert property (p_vec_off)
    else $error("vector offered while globally disabled");

  property p_poll_read;
    (readTake && hitReq) |=> !avs_waitrequest ##0
      (avs_readdata[6:5] == $past(s_q.req[6:5]));
  endproperty
  a_poll_read: assert property (p_poll_read)
    else $error("timer pending bits misread");

  property p_req_rsvd;
    (s_q.req & ~IMPL) == 8'h00;
  endproperty
  a_req_rsvd: assert property (p_req_rsvd)
    else $error("reserved request bit set");

  property p_enl_rsvd;
    (readTake && hitEnl) |=> (avs_readdata[7:0] == ($past(s_q.enl) & IMPL))
      && (avs_readdata[7:0] & ~IMPL) == 8'h00;
  endproperty
  a_enl_rsvd: assert property (p_enl_rsvd)
    else $error("low enable readback wrong");

  property p_enh_write;
    (writeTake && hitEnh) |=> (s_q.enh == ($past(wByte) & IMPL));
  endproperty
  a_enh_write: assert property (p_enh_write)
    else $error("high enable write not stored");

  property p_trap_pass;
    (trapIn != $past(trapIn)) |=> (trapOut == $past(trapIn));
  endproperty
  a_trap_pass: assert property (p_trap_pass)
    else $error("trap did not bypass enables");

  property p_prio_off;
    ((s_q.enh | s_q.enl) == 8'h00) |=> !vecReq;
  endproperty
  a_prio_off: assert property (p_prio_off)
    else $error("disabled source vectored");

  property p_prio_level;
    win.valid |-> (win.level == ire_level_e'({s_q.enh[win.source], s_q.enl[win.source]}))
      && s_q.req[win.source];
  endproperty
  a_prio_level: assert property (p_prio_level)
    else $error("winner level mismatch");

  property p_bus_answer;
    avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_bus_answer: assert property (p_bus_answer)
    else $error("bus answer late");

  property p_req_write;
    (writeTake && hitReq && !ackTake)
      |=> (s_q.req == (($past(wByte) | $past(srcVec)) & IMPL));
  endproperty
  a_req_write: assert property (p_req_write)
    else $error("request write not stored");

  property p_enl_write;
    (writeTake && hitEnl) |=> (s_q.enl == ($past(wByte) & IMPL));
  endproperty
  a_enl_write: assert property (p_enl_write)
    else $error("low enable write not stored");

  property p_be_ignore;
    (avs_write && !avs_byteenable[0] && !avs_waitrequest)
      |=> ($stable(s_q.enh) && $stable(s_q.enl) && $stable(s_q.mask));
  endproperty
  a_be_ignore: assert property (p_be_ignore)
    else $error("write without low byte lane changed a register");

  property p_misaligned;
    (readTake && !aligned) |=> (avs_readdata == 32'h0000_0000);
  endproperty
  a_misaligned: assert property (p_misaligned)
    else $error("misaligned read returned data");

  property p_read_upper;
    avs_readdata[`IRE_DATA_W-1:`IRE_REG_W] == 24'h00_0000;
  endproperty
  a_read_upper: assert property (p_read_upper)
    else $error("read data upper bits set");

  property p_ack_clear;
    (ackTake && !srcVec[s_q.vec.source]) |=> !s_q.req[$past(s_q.vec.source)];
  endproperty
  a_ack_clear: assert property (p_ack_clear)
    else $error("taken vector left pending");

  property p_ack_drop;
    ackTake |=> !vecReq;
  endproperty
  a_ack_drop: assert property (p_ack_drop)
    else $error("vector offered again right after ack");

  property p_stat_set;
    (srcVec != 8'h00) |=> ((s_q.stat & $past(srcVec)) == $past(srcVec));
  endproperty
  a_stat_set: assert property (p_stat_set)
    else $error("status bit not set by request");

  property p_stat_clear;
    (writeTake && hitClr) |=> ((s_q.stat & $past(wByte & ~srcVec)) == 8'h00);
  endproperty
  a_stat_clear: assert property (p_stat_clear)
    else $error("status bit not cleared");

  property p_irq_level;
    irqOut == (|(s_q.stat & s_q.mask));
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("interrupt output disagrees with status");

  c_vec_ack: cover property (vecReq && vecAck);
  c_poll: cover property (!globalIntEnable && readTake && hitReq && (s_q.req != 8'h00));
  c_set_clr: cover property (writeTake && hitClr && ((wByte & srcVec) != 8'h00));
  c_high: cover property (vecReq && vecLevel == IRE_LVL_HIGH);

endmodule

// ---- hdl/README_unused.sv ----
`timescale 1ns/10ps

// ---- test/ire_core_model.sv ----
// Core model taking offered vectors after a chosen delay
`timescale 1ns/10ps
module ire_core_model (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic vecReq,
  input wire logic ackEnable,
  input wire logic [3:0] ackDelay,
  output logic vecAck
);
  logic [3:0] waitCnt;
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      vecAck <= 1'b0;
      waitCnt <= 4'h0;
    end else begin
      vecAck <= 1'b0;
      if (!vecReq || vecAck) begin
        waitCnt <= 4'h0;
      end else if (ackEnable && waitCnt >= ackDelay) begin
        vecAck <= 1'b1;
      end else if (waitCnt != 4'hf) begin
        waitCnt <= waitCnt + 4'h1;
      end
    end
  end
endmodule

// ---- test/testbench.sv ----
// Self-checking bench for the request and enable bank
`timescale 1ns/10ps
`include "ire_cfg.svh"
module testbench;
  import ire_pkg::*;
  logic sys_clk, nrst, rd, wr, gie, ackEn, vecAck, vecReq, waitReq, irq;
  logic [`IRE_ADDR_W-1:0] addr;
  logic [31:0] wdata, rdata, got;
  logic [3:0] be, ackDly;
  logic [2:0] vecSrc;
  ire_level_e vecLvl;
  ire_src_s src;
  ire_trap_s trapIn, trapOut;
  logic [31:0] seed = 32'h0000_2530;
  logic [1:0] lowBits = 2'h0;
  int failures, numChecks, cycles, req, enh, enl, stat, mask, e, n;
  int bits[5] = '{0, 3, 4, 5, 6};

  ire_request_enable_bank dut_u (.sys_clk(sys_clk), .nrst(nrst), .avs_address(addr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wdata), .avs_byteenable(be),
    .avs_readdata(rdata), .avs_waitrequest(waitReq), .sources(src), .globalIntEnable(gie),
    .vecAck(vecAck), .vecReq(vecReq), .vecSource(vecSrc), .vecLevel(vecLvl),
    .trapIn(trapIn), .trapOut(trapOut), .irqOut(irq));
  ire_core_model core_u (.sys_clk(sys_clk), .nrst(nrst), .vecReq(vecReq),
    .ackEnable(ackEn), .ackDelay(ackDly), .vecAck(vecAck));

  // ****************************************
  // Helpers
  // ****************************************
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      test_done();
    end
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic int pick(int p);
    int best, lv;
    best = 0;
    foreach (bits[i]) begin
      lv = 2 * ((enh >> bits[i]) & 1) + ((enl >> bits[i]) & 1);
      if (((p >> bits[i]) & 1) && lv != 0 && lv >= (best & 3)) best = 32 + bits[i] * 4 + lv;
    end
    return best;
  endfunction
  task automatic test_done();
    $display("checks %0d mismatches %0d", numChecks, failures);
    if (failures == 0 && numChecks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic cmpReg(input logic [31:0] g, input logic [31:0] x);
    numChecks++;
    if (g !== x) begin
      failures++;
      $display("unexpected register at %0t: %h vs %h", $time, g, x);
    end
  endtask
  task automatic cmpPin(input logic [31:0] g, input logic [31:0] x);
    numChecks++;
    if (g !== x) begin
      failures++;
      $display("unexpected pin at %0t: %h vs %h", $time, g, x);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] idx, input logic [31:0] d);
    @(posedge sys_clk);
    rd <= !w;
    wr <= w;
    addr <= {idx, lowBits};
    wdata <= d;
    do begin
      @(posedge sys_clk);
    end while (waitReq !== 1'b0);
    got = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic chkReg(input logic [11:0] idx, input int x);
    bus(1'b0, idx, 32'h0000_0000);
    cmpReg(got, x);
  endtask
  task automatic chkAll();
    chkReg(`IRE_IDX_REQ, req);
    chkReg(`IRE_IDX_ENH, enh);
    chkReg(`IRE_IDX_ENL, enl);
    chkReg(`IRE_IDX_STAT, stat);
    chkReg(`IRE_IDX_MASK, mask);
    chkReg(`IRE_IDX_CLR, 0);
    chkReg(12'hfc3, 0);
  endtask
  task automatic pulse(input logic [4:0] s);
    @(posedge sys_clk);
    src <= s;
    @(posedge sys_clk);
    src <= 5'h00;
    req |= {s[4:1], 2'h0, s[0]};
    stat |= {s[4:1], 2'h0, s[0]};
  endtask

  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    nrst = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    addr = '0;
    wdata = '0;
    be = 4'hf;
    src = 5'h00;
    trapIn = 3'h0;
    gie = 1'b0;
    ackEn = 1'b0;
    ackDly = 4'h0;
    repeat (5) @(posedge sys_clk);
    nrst <= 1'b1;
    chkAll();
    bus(1'b1, `IRE_IDX_REQ, 32'h0000_00ff);
    bus(1'b1, `IRE_IDX_ENH, 32'h0000_00ff);
    bus(1'b1, `IRE_IDX_ENL, 32'h0000_00ff);
    bus(1'b1, `IRE_IDX_STAT, 32'h0000_00ff);
    be <= 4'h0;
    bus(1'b1, `IRE_IDX_MASK, 32'h0000_00ff);
    be <= 4'hf;
    req = 8'h79;
    enh = 8'h79;
    enl = 8'h79;
    chkAll();
    lowBits = 2'h2;
    chkReg(`IRE_IDX_ENL, 0);
    lowBits = 2'h0;
    bus(1'b1, `IRE_IDX_REQ, 32'h0000_0000);
    req = 0;
    for (int i = 0; i < 9; i++) begin
      pulse(i < 5 ? 5'h01 << i : rnd());
      chkReg(`IRE_IDX_REQ, req);
      repeat (2) @(posedge sys_clk);
      cmpPin(vecReq, 0);
      chkReg(`IRE_IDX_REQ, req);
    end
    for (int i = 0; i < 4; i++) begin
      mask = i[0] ? rnd() & 8'h79 : 0;
      bus(1'b1, `IRE_IDX_MASK, mask);
      pulse(rnd());
      repeat (2) @(posedge sys_clk);
      cmpPin(irq, (stat & mask) != 0);
      bus(1'b1, `IRE_IDX_CLR, 32'h0000_00ff);
      stat = 0;
      repeat (2) @(posedge sys_clk);
      cmpPin(irq, 0);
      chkAll();
    end
    gie <= 1'b1;
    for (int i = 0; i < 12; i++) begin
      enh = rnd() & 8'h79;
      enl = rnd() & 8'h79;
      req = rnd() & 8'h79;
      bus(1'b1, `IRE_IDX_ENH, enh);
      bus(1'b1, `IRE_IDX_ENL, enl);
      bus(1'b1, `IRE_IDX_REQ, req);
      repeat (3) @(posedge sys_clk);
      e = pick(req);
      if (e == 0) cmpPin(vecReq, 0);
      else cmpPin({vecReq, vecSrc, vecLvl}, e);
      if (e != 0) begin
        ackDly <= i[0] ? 4'h3 : 4'h0;
        ackEn <= 1'b1;
        n = 0;
        while (vecAck !== 1'b1 && n < 20) begin
          @(posedge sys_clk);
          n++;
        end
        ackEn <= 1'b0;
        req &= ~(1 << ((e >> 2) & 7));
        chkReg(`IRE_IDX_REQ, req);
      end
    end
    gie <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      e = rnd() & 7;
      @(posedge sys_clk);
      trapIn <= e[2:0];
      repeat (2) @(posedge sys_clk);
      cmpPin(trapOut, e);
    end
    test_done();
  end
endmodule
